/* File: pkg/serial_slave_pkg.sv */
// constants, types and byte layouts of the serial slave request checker
package serial_slave_pkg;

  // ****************************************************************
  // line timing
  // ****************************************************************
  localparam longint CLK_HZ         = 64'd100_000_000;
  localparam longint BAUD_BPS       = 64'd9600;
  localparam longint CHAR_BITS      = 64'd11;
  // 3.5 characters, held as half characters
  localparam longint GAP_HALF_CHARS = 64'd7;
  localparam longint GAP_CYCLES_CALC =
    (GAP_HALF_CHARS * CHAR_BITS * CLK_HZ + 64'd2 * BAUD_BPS - 64'd1) /
    (64'd2 * BAUD_BPS);
  localparam int     GAP_CYCLES_DEFAULT = int'(GAP_CYCLES_CALC);
  localparam int     GAP_W              = 20;

  // ****************************************************************
  // frame layout
  // ****************************************************************
  localparam int         BUF_AW      = 4;
  localparam int         BUF_DEPTH   = 16;
  localparam logic [4:0] LEN_MIN     = 5'h04;
  localparam logic [4:0] LEN_STD     = 5'h08;
  localparam logic [4:0] LEN_OVF     = 5'h10;
  localparam logic [3:0] IDX_ADDR    = 4'h0;
  localparam logic [3:0] IDX_FUNC    = 4'h1;
  localparam logic [3:0] IDX_REG_HI  = 4'h2;
  localparam logic [3:0] IDX_REG_LO  = 4'h3;
  localparam logic [3:0] IDX_DATA_HI = 4'h4;
  localparam logic [3:0] IDX_DATA_LO = 4'h5;
  localparam logic [3:0] LEN_ECHO    = 4'h8;
  localparam logic [3:0] PLEN_READ   = 4'h5;
  localparam logic [3:0] PLEN_ERR    = 4'h3;
  localparam logic [3:0] CRC_BYTES   = 4'h2;

  // ****************************************************************
  // crc
  // ****************************************************************
  localparam logic [15:0] CRC_INIT    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;

  // ****************************************************************
  // function codes and error codes
  // ****************************************************************
  localparam logic [7:0] FUNC_READ      = 8'h03;
  localparam logic [7:0] FUNC_WRITE_ONE = 8'h06;
  localparam logic [7:0] EXC_FLAG       = 8'h80;
  localparam logic [7:0] READ_BYTES     = 8'h02;
  localparam logic [7:0] ERR_NONE       = 8'h00;
  localparam logic [7:0] ERR_CMD        = 8'h01;
  localparam logic [7:0] ERR_ADDR       = 8'h02;
  localparam logic [7:0] ERR_VALUE      = 8'h03;
  localparam logic [7:0] ERR_OPERATION  = 8'h04;
  localparam logic [7:0] ERR_PASSWORD   = 8'h05;
  localparam logic [7:0] ERR_FRAME      = 8'h06;
  localparam logic [7:0] ERR_READ_ONLY  = 8'h07;
  localparam logic [7:0] ERR_RUNNING    = 8'h08;
  localparam logic [7:0] ERR_LOCKED     = 8'h09;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [15:0] ADDR_RUN_CTRL   = 16'h2000;
  localparam logic [15:0] ADDR_STATUS     = 16'h2100;
  localparam logic [15:0] ADDR_PASSWORD   = 16'h1F00;
  localparam logic [15:0] ADDR_RUN_LOCKED = 16'h0001;
  localparam logic [15:0] RUN_FWD         = 16'h0001;
  localparam logic [15:0] RUN_STOP        = 16'h0005;
  localparam logic [15:0] QTY_ONE         = 16'h0001;
  localparam logic [15:0] QTY_MAX         = 16'h0010;
  localparam logic [15:0] QTY_ZERO        = 16'h0000;
  localparam logic [15:0] PASSWORD_NONE   = 16'h0000;
  localparam logic [15:0] RESET_WORD      = 16'h0000;

  typedef enum logic [1:0] {KIND_ECHO, KIND_READ, KIND_ERR} resp_kind_t;
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_SEND} tx_state_t;

endpackage

/* File: core/serial_frame_buffer.sv */
// byte store for one received frame, registered read
`timescale 1ns/1ps
module serial_frame_buffer (
  input  wire logic                               ref_clk_i,
  input  wire logic                               rst_b_i,
  input  wire logic                               we_i,
  input  wire logic [serial_slave_pkg::BUF_AW-1:0] waddr_i,
  input  wire logic [7:0]                         wdata_i,
  input  wire logic [serial_slave_pkg::BUF_AW-1:0] raddr_i,
  output logic      [7:0]                         rdata_o
);

  logic [7:0] mem [serial_slave_pkg::BUF_DEPTH];

  always_ff @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule // serial_frame_buffer

/* File: core/serial_slave_error_responder.sv */
// request checker, error responder and run command of the serial slave
`timescale 1ns/1ps
module serial_slave_error_responder #(
  parameter int GAP_CYCLES = serial_slave_pkg::GAP_CYCLES_DEFAULT
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        tx_ready_i,
  input  wire logic [7:0]  station_address_setting_i,
  input  wire logic [15:0] user_password_setting_i,
  input  wire logic        run_command_source_comm_i,
  input  wire logic        comm_run_channel_serial_i,
  input  wire logic        drive_fault_i,
  output logic      [7:0]  tx_data_o,
  output logic             tx_valid_o,
  output logic             forward_run_o,
  output logic      [7:0]  last_code_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  serial_slave_pkg::tx_state_t  state, next_state;
  serial_slave_pkg::resp_kind_t kind, next_kind;
  logic [serial_slave_pkg::GAP_W-1:0] gap_cnt, next_gap_cnt;
  logic [4:0]  rx_len, next_rx_len;
  logic [15:0] rx_crc, next_rx_crc;
  logic [7:0]  req_addr, next_req_addr;
  logic [7:0]  req_func, next_req_func;
  logic [15:0] reg_addr, next_reg_addr;
  logic [15:0] data_val, next_data_val;
  logic [15:0] run_ctrl, next_run_ctrl;
  logic [15:0] lock_param, next_lock_param;
  logic        forward_run, next_forward_run;
  logic        unlocked, next_unlocked;
  logic [7:0]  resp_code, next_resp_code;
  logic [15:0] rd_data, next_rd_data;
  logic [3:0]  tx_idx, next_tx_idx;
  logic [15:0] tx_crc, next_tx_crc;
  logic [7:0]  tx_data, next_tx_data;
  logic        tx_valid, next_tx_valid;
  logic [7:0]  last_code, next_last_code;

  logic        gap_full, frame_end, accept, mem_we;
  logic        addr_hit, frame_ok, func_known, is_pw_write, locked, mapped;
  logic [7:0]  eval_code, mem_rdata, tx_byte;
  logic [15:0] eval_rd;
  logic [3:0]  tx_plen;
  logic        tx_last;

  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic [7:0]  b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ serial_slave_pkg::CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  serial_frame_buffer u_buf (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .we_i      (mem_we),
    .waddr_i   (rx_len[3:0]),
    .wdata_i   (rx_data_i),
    .raddr_i   (tx_idx),
    .rdata_o   (mem_rdata)
  );

  // ****************************************************************
  // request checking
  // ****************************************************************
  always_comb begin
    gap_full   = gap_cnt == serial_slave_pkg::GAP_W'(GAP_CYCLES);
    frame_end  = state == serial_slave_pkg::ST_IDLE && rx_len != 5'h00 &&
                 !rx_valid_i &&
                 gap_cnt == serial_slave_pkg::GAP_W'(GAP_CYCLES - 1);
    addr_hit   = req_addr == station_address_setting_i;
    frame_ok   = rx_crc == serial_slave_pkg::CRC_RESIDUE &&
                 rx_len >= serial_slave_pkg::LEN_MIN &&
                 rx_len != serial_slave_pkg::LEN_OVF;
    func_known = req_func == serial_slave_pkg::FUNC_READ ||
                 req_func == serial_slave_pkg::FUNC_WRITE_ONE;
    is_pw_write = req_func == serial_slave_pkg::FUNC_WRITE_ONE &&
                  reg_addr == serial_slave_pkg::ADDR_PASSWORD;
    locked     = user_password_setting_i != serial_slave_pkg::PASSWORD_NONE
                 && !unlocked;
    mapped     = reg_addr == serial_slave_pkg::ADDR_RUN_CTRL ||
                 reg_addr == serial_slave_pkg::ADDR_STATUS ||
                 reg_addr == serial_slave_pkg::ADDR_PASSWORD ||
                 reg_addr == serial_slave_pkg::ADDR_RUN_LOCKED;
    eval_code  = serial_slave_pkg::ERR_NONE;
    if (!frame_ok) begin
      eval_code = serial_slave_pkg::ERR_FRAME;
    end else if (drive_fault_i || !func_known) begin
      eval_code = serial_slave_pkg::ERR_CMD;
    end else if (rx_len != serial_slave_pkg::LEN_STD) begin
      eval_code = serial_slave_pkg::ERR_FRAME;
    end else if (locked && !is_pw_write) begin
      eval_code = serial_slave_pkg::ERR_LOCKED;
    end else if (req_func == serial_slave_pkg::FUNC_READ) begin
      if (data_val == serial_slave_pkg::QTY_ZERO ||
          data_val > serial_slave_pkg::QTY_MAX) begin
        eval_code = serial_slave_pkg::ERR_VALUE;
      end else if (!mapped || data_val != serial_slave_pkg::QTY_ONE) begin
        eval_code = serial_slave_pkg::ERR_ADDR;
      end
    end else if (!mapped) begin
      eval_code = serial_slave_pkg::ERR_ADDR;
    end else if (reg_addr == serial_slave_pkg::ADDR_STATUS) begin
      eval_code = serial_slave_pkg::ERR_READ_ONLY;
    end else if (is_pw_write) begin
      if (data_val != user_password_setting_i) begin
        eval_code = serial_slave_pkg::ERR_PASSWORD;
      end
    end else if (reg_addr == serial_slave_pkg::ADDR_RUN_LOCKED &&
                 forward_run) begin
      eval_code = serial_slave_pkg::ERR_RUNNING;
    end else if (reg_addr == serial_slave_pkg::ADDR_RUN_CTRL &&
                 data_val != serial_slave_pkg::RUN_FWD &&
                 data_val != serial_slave_pkg::RUN_STOP) begin
      eval_code = serial_slave_pkg::ERR_OPERATION;
    end
    if (reg_addr == serial_slave_pkg::ADDR_RUN_CTRL) begin
      eval_rd = run_ctrl;
    end else if (reg_addr == serial_slave_pkg::ADDR_STATUS) begin
      eval_rd = 16'(forward_run);
    end else if (reg_addr == serial_slave_pkg::ADDR_RUN_LOCKED) begin
      eval_rd = lock_param;
    end else begin
      eval_rd = serial_slave_pkg::RESET_WORD;
    end
  end

  // ****************************************************************
  // response byte selection
  // ****************************************************************
  always_comb begin
    tx_plen = (kind == serial_slave_pkg::KIND_READ) ?
              serial_slave_pkg::PLEN_READ : serial_slave_pkg::PLEN_ERR;
    tx_last = (kind == serial_slave_pkg::KIND_ECHO) ?
              (tx_idx == serial_slave_pkg::LEN_ECHO - 4'h1) :
              (tx_idx == tx_plen + serial_slave_pkg::CRC_BYTES - 4'h1);
    if (kind == serial_slave_pkg::KIND_ECHO) begin
      tx_byte = mem_rdata;
    end else if (tx_idx == tx_plen) begin
      tx_byte = tx_crc[7:0];
    end else if (tx_idx > tx_plen) begin
      tx_byte = tx_crc[15:8];
    end else if (tx_idx == serial_slave_pkg::IDX_ADDR) begin
      tx_byte = req_addr;
    end else if (tx_idx == serial_slave_pkg::IDX_FUNC) begin
      tx_byte = (kind == serial_slave_pkg::KIND_ERR) ?
                (req_func | serial_slave_pkg::EXC_FLAG) : req_func;
    end else if (tx_idx == serial_slave_pkg::IDX_REG_HI) begin
      tx_byte = (kind == serial_slave_pkg::KIND_ERR) ?
                resp_code : serial_slave_pkg::READ_BYTES;
    end else if (tx_idx == serial_slave_pkg::IDX_REG_LO) begin
      tx_byte = rd_data[15:8];
    end else begin
      tx_byte = rd_data[7:0];
    end
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_state = state;         next_kind = kind;
    next_gap_cnt = gap_cnt;     next_rx_len = rx_len;
    next_rx_crc = rx_crc;       next_req_addr = req_addr;
    next_req_func = req_func;   next_reg_addr = reg_addr;
    next_data_val = data_val;   next_run_ctrl = run_ctrl;
    next_lock_param = lock_param;
    next_forward_run = forward_run;
    next_unlocked = unlocked;   next_resp_code = resp_code;
    next_rd_data = rd_data;     next_tx_idx = tx_idx;
    next_tx_crc = tx_crc;       next_tx_data = tx_data;
    next_tx_valid = tx_valid;   next_last_code = last_code;
    mem_we = 1'b0;
    // a new frame may only open after a full idle gap
    accept = rx_valid_i && state == serial_slave_pkg::ST_IDLE &&
             (rx_len != 5'h00 || gap_full);
    if (rx_valid_i) begin
      next_gap_cnt = '0;
    end else if (!gap_full) begin
      next_gap_cnt = gap_cnt + serial_slave_pkg::GAP_W'(1);
    end
    if (accept && rx_len != serial_slave_pkg::LEN_OVF) begin
      mem_we = 1'b1;
      next_rx_len = rx_len + 5'h01;
      next_rx_crc = crc_step((rx_len == 5'h00) ?
                             serial_slave_pkg::CRC_INIT : rx_crc, rx_data_i);
      case (rx_len[3:0])
        serial_slave_pkg::IDX_ADDR: begin
          next_req_addr = rx_data_i;
          next_req_func = 8'h00;
        end
        serial_slave_pkg::IDX_FUNC:    next_req_func = rx_data_i;
        serial_slave_pkg::IDX_REG_HI:  next_reg_addr[15:8] = rx_data_i;
        serial_slave_pkg::IDX_REG_LO:  next_reg_addr[7:0] = rx_data_i;
        serial_slave_pkg::IDX_DATA_HI: next_data_val[15:8] = rx_data_i;
        serial_slave_pkg::IDX_DATA_LO: next_data_val[7:0] = rx_data_i;
        default: ;
      endcase
    end
    case (state)
      serial_slave_pkg::ST_IDLE: begin
        if (frame_end) begin
          next_rx_len = 5'h00;
          // foreign frames get no reply at all
          if (addr_hit) begin
            next_state = serial_slave_pkg::ST_FETCH;
            next_tx_idx = 4'h0;
            next_tx_crc = serial_slave_pkg::CRC_INIT;
            next_resp_code = eval_code;
            next_last_code = eval_code;
            next_rd_data = eval_rd;
            if (eval_code != serial_slave_pkg::ERR_NONE) begin
              next_kind = serial_slave_pkg::KIND_ERR;
            end else if (req_func == serial_slave_pkg::FUNC_READ) begin
              next_kind = serial_slave_pkg::KIND_READ;
            end else begin
              next_kind = serial_slave_pkg::KIND_ECHO;
              if (is_pw_write) begin
                next_unlocked = 1'b1;
              end else if (reg_addr == serial_slave_pkg::ADDR_RUN_LOCKED) begin
                next_lock_param = data_val;
              end else begin
                next_run_ctrl = data_val;
                if (run_command_source_comm_i &&
                    comm_run_channel_serial_i) begin
                  next_forward_run = data_val == serial_slave_pkg::RUN_FWD;
                end
              end
            end
          end
        end
      end
      serial_slave_pkg::ST_FETCH: next_state = serial_slave_pkg::ST_LOAD;
      serial_slave_pkg::ST_LOAD: begin
        next_tx_data = tx_byte;
        next_tx_valid = 1'b1;
        next_state = serial_slave_pkg::ST_SEND;
      end
      default: begin
        if (tx_ready_i) begin
          next_tx_valid = 1'b0;
          // crc bytes themselves must not fold into the crc
          if (tx_idx < tx_plen) begin
            next_tx_crc = crc_step(tx_crc, tx_data);
          end
          next_tx_idx = tx_idx + 4'h1;
          next_state = tx_last ? serial_slave_pkg::ST_IDLE :
                                 serial_slave_pkg::ST_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state <= serial_slave_pkg::ST_IDLE;
      kind <= serial_slave_pkg::KIND_ERR;
      gap_cnt <= '0;                rx_len <= 5'h00;
      rx_crc <= serial_slave_pkg::CRC_INIT;
      req_addr <= 8'h00;            req_func <= 8'h00;
      reg_addr <= serial_slave_pkg::RESET_WORD;
      data_val <= serial_slave_pkg::RESET_WORD;
      run_ctrl <= serial_slave_pkg::RESET_WORD;
      lock_param <= serial_slave_pkg::RESET_WORD;
      forward_run <= 1'b0;          unlocked <= 1'b0;
      resp_code <= serial_slave_pkg::ERR_NONE;
      rd_data <= serial_slave_pkg::RESET_WORD;
      tx_idx <= 4'h0;               tx_crc <= serial_slave_pkg::CRC_INIT;
      tx_data <= 8'h00;             tx_valid <= 1'b0;
      last_code <= serial_slave_pkg::ERR_NONE;
    end else begin
      state <= next_state;          kind <= next_kind;
      gap_cnt <= next_gap_cnt;      rx_len <= next_rx_len;
      rx_crc <= next_rx_crc;        req_addr <= next_req_addr;
      req_func <= next_req_func;    reg_addr <= next_reg_addr;
      data_val <= next_data_val;    run_ctrl <= next_run_ctrl;
      lock_param <= next_lock_param;
      forward_run <= next_forward_run;
      unlocked <= next_unlocked;    resp_code <= next_resp_code;
      rd_data <= next_rd_data;      tx_idx <= next_tx_idx;
      tx_crc <= next_tx_crc;        tx_data <= next_tx_data;
      tx_valid <= next_tx_valid;    last_code <= next_last_code;
    end
  end

  assign tx_data_o     = tx_data;
  assign tx_valid_o    = tx_valid;
  assign forward_run_o = forward_run;
  assign last_code_o   = last_code;

  // ****************************************************************
  // checks
  // ****************************************************************
  AST_FOREIGN_SILENT: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    frame_end && !addr_hit |=> state == serial_slave_pkg::ST_IDLE [*3])
    else $error("frame for another station was answered");
  AST_BAD_CRC: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    frame_end && addr_hit && rx_crc != serial_slave_pkg::CRC_RESIDUE |=>
    resp_code == serial_slave_pkg::ERR_FRAME &&
    kind == serial_slave_pkg::KIND_ERR)
    else $error("bad crc not answered with frame error");
  AST_FAULT_CMD: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    frame_end && addr_hit && frame_ok && drive_fault_i |=>
    resp_code == serial_slave_pkg::ERR_CMD)
    else $error("faulty drive did not answer invalid command");
  AST_PW_MISMATCH: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    frame_end && addr_hit && frame_ok && !drive_fault_i &&
    rx_len == serial_slave_pkg::LEN_STD && is_pw_write &&
    data_val != user_password_setting_i |=>
    resp_code == serial_slave_pkg::ERR_PASSWORD && !$changed(unlocked))
    else $error("wrong password not refused");
  AST_FWD_START: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(forward_run_o) |-> $past(frame_end) &&
    $past(req_func) == serial_slave_pkg::FUNC_WRITE_ONE &&
    $past(reg_addr) == serial_slave_pkg::ADDR_RUN_CTRL &&
    $past(data_val) == serial_slave_pkg::RUN_FWD)
    else $error("forward run started without run write");
  AST_RUN_SOURCE: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    $changed(forward_run_o) |->
    $past(run_command_source_comm_i && comm_run_channel_serial_i))
    else $error("run state changed with serial run disabled");
  AST_ERR_FLAG: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    tx_valid_o && kind == serial_slave_pkg::KIND_ERR &&
    tx_idx == serial_slave_pkg::IDX_FUNC |->
    tx_data_o == (req_func | serial_slave_pkg::EXC_FLAG))
    else $error("error reply lacks flagged function code");
  AST_ECHO_COPY: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    tx_valid_o && kind == serial_slave_pkg::KIND_ECHO &&
    tx_idx <= serial_slave_pkg::IDX_DATA_LO |->
    tx_data_o == ((tx_idx == serial_slave_pkg::IDX_ADDR) ? req_addr :
      (tx_idx == serial_slave_pkg::IDX_FUNC) ? req_func :
      (tx_idx == serial_slave_pkg::IDX_REG_HI) ? reg_addr[15:8] :
      (tx_idx == serial_slave_pkg::IDX_REG_LO) ? reg_addr[7:0] :
      (tx_idx == serial_slave_pkg::IDX_DATA_HI) ? data_val[15:8] :
      data_val[7:0]))
    else $error("write echo differs from request");
  AST_REPLY_CAUSE: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(tx_valid_o) && tx_idx == 4'h0 |-> $past(frame_end, 3))
    else $error("reply started without a request");
  AST_TX_HOLD: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
    else $error("reply byte dropped before it was taken");

endmodule // serial_slave_error_responder

/* File: verification/bus_master_model.sv */
// bus master partner: takes reply bytes with random stalls
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic       ref_clk_i,
  input  wire logic       tx_valid_i,
  input  wire logic [7:0] tx_data_i,
  output logic            tx_ready_o
);
  logic [7:0] got[$];
  initial tx_ready_o = 1'b0;
  // collects only what the slave offers, never sends unasked
  always @(posedge ref_clk_i) begin
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_data_i);
    #1 tx_ready_o = ($urandom % 3) != 0;
  end
endmodule // bus_master_model

/* File: verification/serial_slave_error_responder_tb.sv */
// testbench of the serial slave error responder
`timescale 1ns/1ps
module serial_slave_error_responder_tb;
  typedef logic [7:0] bq_t[$];
  logic        ref_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        rx_valid_i = 1'b0;
  logic [7:0]  rx_data_i = 8'h00;
  logic [15:0] pw = 16'h0000;
  logic [15:0] c;
  logic [7:0]  tx_data, code, e;
  logic        tx_valid, ready, fwd;
  logic        src = 1'b1, fault = 1'b0;
  int          num_errors = 0, total_checks = 0, cyc = 0;
  logic [55:0] tv[15];
  bq_t         fr, ex;
  serial_slave_error_responder #(.GAP_CYCLES(20)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .rx_data_i(rx_data_i),
    .rx_valid_i(rx_valid_i), .tx_ready_i(ready),
    .station_address_setting_i(8'h03), .user_password_setting_i(pw),
    .run_command_source_comm_i(src), .comm_run_channel_serial_i(1'b1),
    .drive_fault_i(fault), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
    .forward_run_o(fwd), .last_code_o(code));
  bus_master_model u_mst (.ref_clk_i(ref_clk_i), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_ready_o(ready));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 6000) begin
      num_errors++;
      conclude();
    end
  end
  function automatic logic [15:0] crc16(bq_t b);
    logic [15:0] r;
    r = 16'hFFFF;
    foreach (b[i]) begin
      r ^= {8'h00, b[i]};
      repeat (8) r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
    end
    return r;
  endfunction
  task chk(string n, logic [15:0] x, logic [15:0] g);
    total_checks++;
    if (g !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    void'($urandom(77132));
    pw = 16'($urandom % 16'hFFFE) + 16'h0001;
    // FE marks a good read, FF a frame for another station
    tv = '{{32'h03060001, 16'h0100, 8'h09},
      {32'h03061F00, pw ^ 16'h0001, 8'h05},
      {32'h03061F00, pw, 8'h00}, {48'h030520000001, 8'h01},
      {48'h030312340001, 8'h02}, {48'h030320000000, 8'h03},
      {48'h030620000007, 8'h04}, {48'h030621000001, 8'h07},
      {48'h030620000005, 8'h06}, {48'h030620000001, 8'h00},
      {48'h030320000001, 8'hFE}, {32'h03060001, 16'h0100, 8'h08},
      {48'h030620000005, 8'h00}, {48'h030620000001, 8'h01},
      {48'h040620000005, 8'hFF}};
    tv[11][23:8] = 16'($urandom);
    repeat (4) @(posedge ref_clk_i);
    #1 rst_b_i = 1'b1;
    repeat (22) @(posedge ref_clk_i);
    #1;
    foreach (tv[t]) begin
      e = tv[t][7:0];
      src = (t != 12);
      fault = (t == 13);
      fr = {};
      for (int i = 5; i >= 0; i--) fr.push_back(tv[t][8+8*i +: 8]);
      c = crc16(fr);
      fr.push_back(c[7:0] ^ 8'(e == 8'h06));
      fr.push_back(c[15:8]);
      // run control reads back the 0001 stored by the test just before
      if (e == 8'h00) ex = fr;
      else if (e == 8'hFF) ex = {};
      else if (e == 8'hFE) ex = {fr[0], fr[1], 8'h02, 8'h00, 8'h01};
      else ex = {fr[0], fr[1] | 8'h80, e};
      if (e != 8'h00 && e != 8'hFF) begin
        c = crc16(ex);
        ex = {ex, c[7:0], c[15:8]};
      end
      u_mst.got.delete();
      foreach (fr[i]) begin
        rx_data_i = fr[i];
        rx_valid_i = 1'b1;
        @(posedge ref_clk_i);
        #1;
      end
      rx_valid_i = 1'b0;
      for (int k = 0; k < 200 && u_mst.got.size() < ex.size(); k++)
        @(posedge ref_clk_i);
      repeat (25) @(posedge ref_clk_i);
      #1;
      chk("reply length", 16'(ex.size()), 16'(u_mst.got.size()));
      foreach (ex[i]) chk("reply byte", ex[i], u_mst.got[i]);
      if (e != 8'hFF) chk("last code", (e == 8'hFE) ? 8'h00 : e, code);
      $display("test %0d done", t);
    end
    chk("forward run", 16'h0001, fwd);
    conclude();
  end
endmodule // serial_slave_error_responder_tb
